// >>> rtl/drv_ctl_pkg.sv
// constants and types for the quad pin-driver control decode.
// assumes one 100 MHz clock and a parallel configuration write port.
package drv_ctl_pkg;

    localparam int NCH = 4;

    // one-hot output state positions
    localparam int SEL_W     = 6;
    localparam int SEL_LOW   = 0;
    localparam int SEL_HIGH  = 1;
    localparam int SEL_TERM  = 2;
    localparam int SEL_HIZ   = 3;
    localparam int SEL_HV    = 4;
    localparam int SEL_LEAK  = 5;

    // field widths
    localparam int SLEW_W  = 2;
    localparam int DROOP_W = 3;
    localparam int RES_W   = 4;
    localparam int CFG_W   = 4;

    // reset values
    localparam logic [SLEW_W-1:0]  SLEW_RST  = 2'h0;
    localparam logic [DROOP_W-1:0] DROOP_RST = 3'h0;
    localparam logic [RES_W-1:0]   RES_RST   = 4'h8;

    // slew code to percent of full multiplexer speed
    localparam int SLEW_PCT [4] = '{100, 75, 50, 25};
    // droop code to compensation in tenths of a percent
    localparam int DROOP_PCT_X10 [8] = '{0, 21, 43, 64, 86, 107, 129, 150};
    // trim step in milliohm, zero offset at code RES_RST
    localparam int RES_STEP_MOHM = 360;

    // configuration field selector
    typedef enum logic [2:0] {
        F_LOW_LEAK   = 3'h0,
        F_HV_ON_RCV  = 3'h1,
        F_TERM_DRIVE = 3'h2,
        F_SLEW       = 3'h3,
        F_DROOP_LONG = 3'h4,
        F_DROOP_SHRT = 3'h5,
        F_OUT_RES    = 3'h6
    } cfg_field_e;

endpackage

// >>> rtl/drv_mode_decode.sv
// one channel's output-state decoder, purely combinational.
// assumes all inputs already sit in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module drv_mode_decode
    import drv_ctl_pkg::*;
(
    // control
    input  wire logic             low_leak_sel,
    input  wire logic             hv_on_receive_sel,
    input  wire logic             term_drive_sel,
    input  wire logic             hv_enable_n,
    // high-speed
    input  wire logic             receive_ctl,
    input  wire logic             drive_data,
    // result
    output logic [SEL_W-1:0]      state_sel
);
    always_comb begin
        state_sel = '0;
        if (low_leak_sel) begin
            state_sel[SEL_LEAK] = 1'b1;
        end else if (!hv_enable_n) begin
            state_sel[SEL_HV] = 1'b1;
        end else if (receive_ctl && hv_on_receive_sel) begin
            state_sel[SEL_HV] = 1'b1;
        end else if (receive_ctl) begin
            state_sel[term_drive_sel ? SEL_TERM : SEL_HIZ] = 1'b1;
        end else begin
            // hv select deliberately not looked at here
            state_sel[drive_data ? SEL_HIGH : SEL_LOW] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/pin_driver_mode_control.sv
// top of the quad pin-driver control decode and its configuration bits.
// assumes data and receive come from tester logic on clk; the hv enable
// pin and the serial-port reset pin are asynchronous and are synchronised.
//
// What this block does
// - low leak bit forces low leak state
// - other states need low leak bit clear
// - each channel has own low leak bit
// - enable high, receive low: data picks level
// - receive high, no hv: term bit picks
// - hv enable pin low forces hv drive
// - hv select plus receive gives hv drive
// - hv select ignored while receive is low
// - slew code selects 100/75/50/25 percent
// - slew code cleared at reset and port reset
// - two 3-bit droop codes per channel
// - short droop code linear 0 to 15 percent
// - long droop code same mapping
// - droop codes reset to 000
// - output resistance trim about plus minus 2.5
// - trim code resets to 1000, 0.36 steps
`timescale 1ns/1ps
`default_nettype none
module pin_driver_mode_control
    import drv_ctl_pkg::*;
#(
    parameter int N_CH = NCH
) (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    // external pins
    input  wire logic                                   hv_enable_n_pin,
    input  wire logic                                   serial_reset_n_pin,
    // high-speed controls from tester timing logic
    input  wire logic [N_CH-1:0]                        receive_ctl,
    input  wire logic [N_CH-1:0]                        drive_data,
    // configuration write port
    input  wire logic                                   cfg_wr,
    input  wire logic [N_CH-1:0]                        cfg_chan_mask,
    input  wire drv_ctl_pkg::cfg_field_e                cfg_field,
    input  wire logic [drv_ctl_pkg::CFG_W-1:0]          cfg_data,
    // to the analog multiplexer
    output logic [N_CH-1:0][drv_ctl_pkg::SEL_W-1:0]     channel_drive_control,
    // held trim codes
    output logic [N_CH-1:0][drv_ctl_pkg::SLEW_W-1:0]    slew_code,
    output logic [N_CH-1:0][drv_ctl_pkg::DROOP_W-1:0]   droop_long_code,
    output logic [N_CH-1:0][drv_ctl_pkg::DROOP_W-1:0]   droop_short_code,
    output logic [N_CH-1:0][drv_ctl_pkg::RES_W-1:0]     out_resistance_code,
    // readback of mode bits
    output logic [N_CH-1:0]                             low_leak_sel,
    output logic [N_CH-1:0]                             hv_on_receive_sel,
    output logic [N_CH-1:0]                             term_drive_sel
);
    import drv_ctl_pkg::*;

    // ********************************************************
    // elaboration checks
    // ********************************************************
    // field selector and port widths are fixed by the package
    if (N_CH != NCH) begin : g_bad_nch
        $error("pin_driver_mode_control: only %0d channels supported", NCH);
    end
    // a field wider than the data word could never be written whole
    if (CFG_W < RES_W || CFG_W < DROOP_W || CFG_W < SLEW_W) begin : g_bad_cfg
        $error("pin_driver_mode_control: config data narrower than a field");
    end
    if (SEL_W != SEL_LEAK + 1) begin : g_bad_sel
        $error("pin_driver_mode_control: select width does not cover all states");
    end

    // ********************************************************
    // helpers
    // ********************************************************
    // a write lands on a channel only when strobed and masked in
    function automatic logic chan_hit(input logic wr, input logic [N_CH-1:0] mask, input int c);
        return wr && mask[c];
    endfunction

    // single-bit mode fields take bit 0 of the data word
    function automatic logic mode_bit(input logic [CFG_W-1:0] d);
        return d[0];
    endfunction

    // two-flop synchroniser step, new sample enters at bit 0
    function automatic logic [1:0] sync_shift(input logic [1:0] q, input logic d);
        return {q[0], d};
    endfunction

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic [1:0]                         hv_sync;
        logic [1:0]                         srst_sync;
        logic [N_CH-1:0]                    leak;
        logic [N_CH-1:0]                    hv_rcv;
        logic [N_CH-1:0]                    term;
        logic [N_CH-1:0][SLEW_W-1:0]        slew;
        logic [N_CH-1:0][DROOP_W-1:0]       dl;
        logic [N_CH-1:0][DROOP_W-1:0]       ds;
        logic [N_CH-1:0][RES_W-1:0]         res;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // only the second flop of each synchroniser is ever read
    logic   hv_enable_n_sync;
    logic   serial_reset_n_sync;

    assign hv_enable_n_sync    = st_r.hv_sync[1];
    assign serial_reset_n_sync = st_r.srst_sync[1];

    // ********************************************************
    // configuration update
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        // pins are asynchronous: two flops before use
        st_nxt.hv_sync   = sync_shift(st_r.hv_sync, hv_enable_n_pin);
        st_nxt.srst_sync = sync_shift(st_r.srst_sync, serial_reset_n_pin);
        for (int c = 0; c < N_CH; c++) begin
            if (chan_hit(cfg_wr, cfg_chan_mask, c)) begin
                unique case (cfg_field)
                    F_LOW_LEAK:   st_nxt.leak[c]   = mode_bit(cfg_data);
                    F_HV_ON_RCV:  st_nxt.hv_rcv[c] = mode_bit(cfg_data);
                    F_TERM_DRIVE: st_nxt.term[c]   = mode_bit(cfg_data);
                    F_SLEW:       st_nxt.slew[c]   = cfg_data[SLEW_W-1:0];
                    F_DROOP_LONG: st_nxt.dl[c]     = cfg_data[DROOP_W-1:0];
                    F_DROOP_SHRT: st_nxt.ds[c]     = cfg_data[DROOP_W-1:0];
                    F_OUT_RES:    st_nxt.res[c]    = cfg_data[RES_W-1:0];
                    default: ;
                endcase
            end
            // port reset wins over a same-cycle slew write
            if (!serial_reset_n_sync) begin
                st_nxt.slew[c] = SLEW_RST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r           <= '0;
            st_r.hv_sync   <= 2'h3;
            st_r.srst_sync <= 2'h3;
            for (int c = 0; c < N_CH; c++) begin
                st_r.slew[c] <= SLEW_RST;
                st_r.dl[c]   <= DROOP_RST;
                st_r.ds[c]   <= DROOP_RST;
                st_r.res[c]  <= RES_RST;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************
    // per-channel decode
    // ********************************************************
    // decode stays combinational so data edges are not delayed a cycle
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        drv_mode_decode u_dec (
            .low_leak_sel      (st_r.leak[c]),
            .hv_on_receive_sel (st_r.hv_rcv[c]),
            .term_drive_sel    (st_r.term[c]),
            .hv_enable_n       (hv_enable_n_sync),
            .receive_ctl       (receive_ctl[c]),
            .drive_data        (drive_data[c]),
            .state_sel         (channel_drive_control[c])
        );
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign slew_code           = st_r.slew;
    assign droop_long_code     = st_r.dl;
    assign droop_short_code    = st_r.ds;
    assign out_resistance_code = st_r.res;
    assign low_leak_sel        = st_r.leak;
    assign hv_on_receive_sel   = st_r.hv_rcv;
    assign term_drive_sel      = st_r.term;

endmodule
`default_nettype wire

// >>> tb/drv_ctl_monitor.sv
// checker on the ports of pin_driver_mode_control.
// assumes one clk domain with sync active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module drv_ctl_monitor
    import drv_ctl_pkg::*;
#(parameter int N_CH = NCH) (
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire logic                         hv_enable_n_pin,
    input wire logic                         serial_reset_n_pin,
    input wire logic [N_CH-1:0]              receive_ctl,
    input wire logic [N_CH-1:0]              drive_data,
    input wire logic [N_CH-1:0][SEL_W-1:0]   channel_drive_control,
    input wire logic [N_CH-1:0][SLEW_W-1:0]  slew_code,
    input wire logic [N_CH-1:0][DROOP_W-1:0] droop_long_code,
    input wire logic [N_CH-1:0][RES_W-1:0]   out_resistance_code,
    input wire logic [N_CH-1:0]              low_leak_sel,
    input wire logic [N_CH-1:0]              hv_on_receive_sel,
    input wire logic [N_CH-1:0]              term_drive_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_leak_forces: assert property (low_leak_sel[0] |-> channel_drive_control[0] == 6'h20)
        else $error("leak bit without leak state");
    a_leak_own_bit: assert property (channel_drive_control[1][SEL_LEAK] == low_leak_sel[1])
        else $error("leak state not tied to own bit");
    a_one_hot: assert property ($onehot(channel_drive_control[2])) else $error("state not one-hot");
    a_data_level: assert property (hv_enable_n_pin[*4] ##0 (!low_leak_sel[3] && !receive_ctl[3]) |->
        channel_drive_control[3] == (drive_data[3] ? 6'h02 : 6'h01)) else $error("wrong drive level");
    a_term_or_hiz: assert property (hv_enable_n_pin[*4] ##0 (!low_leak_sel[0] && receive_ctl[0] &&
        !hv_on_receive_sel[0]) |-> channel_drive_control[0] == (term_drive_sel[0] ? 6'h04 : 6'h08))
        else $error("wrong receive state");
    a_hv_pin: assert property ((!hv_enable_n_pin)[*4] ##0 !low_leak_sel[2] |->
        channel_drive_control[2] == 6'h10) else $error("hv pin ignored");
    a_hv_receive: assert property (!low_leak_sel[0] && receive_ctl[0] && hv_on_receive_sel[0] |->
        channel_drive_control[0] == 6'h10) else $error("hv on receive missing");
    a_slew_port_rst: assert property ((!serial_reset_n_pin)[*5] |-> slew_code == '0)
        else $error("slew not cleared by port reset");
    a_reset_vals: assert property ($rose(reset_n) |-> slew_code == '0 && droop_long_code == '0 &&
        out_resistance_code == {N_CH{RES_RST}} && low_leak_sel == '0) else $error("bad reset values");
    c_leak_hv: cover property (low_leak_sel[1] && !hv_enable_n_pin);
    c_hv_rcv: cover property (receive_ctl[0] && hv_on_receive_sel[0]);
    c_port_rst: cover property ((!serial_reset_n_pin)[*5]);
endmodule
bind pin_driver_mode_control drv_ctl_monitor #(.N_CH(N_CH)) u_mon (.clk, .reset_n, .hv_enable_n_pin,
    .serial_reset_n_pin, .receive_ctl, .drive_data, .channel_drive_control, .slew_code, .droop_long_code,
    .out_resistance_code, .low_leak_sel, .hv_on_receive_sel, .term_drive_sel);
`default_nettype wire

// >>> tb/pin_driver_mode_control_tb_top.sv
// self-checking bench for pin_driver_mode_control.
// assumes the tester model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pin_driver_mode_control_tb_top;
    import drv_ctl_pkg::*;
    logic clk = 0, reset_n = 0, hv_enable_n_pin = 1, serial_reset_n_pin = 1, cfg_wr = 0;
    logic [3:0] want_rcv = 0, want_data = 0, cfg_chan_mask = 0, cfg_data = 0, receive_ctl, drive_data;
    logic [3:0] low_leak_sel, hv_on_receive_sel, term_drive_sel;
    cfg_field_e cfg_field = F_LOW_LEAK;
    logic [3:0][5:0] channel_drive_control;
    logic [3:0][1:0] slew_code;
    logic [3:0][2:0] droop_long_code, droop_short_code;
    logic [3:0][3:0] out_resistance_code;
    int n_fail = 0, checks_done = 0, cyc = 0;
    always #5 clk = ~clk;
    tester_timing_model PTR (.clk, .want_rcv, .want_data, .receive_ctl, .drive_data);
    pin_driver_mode_control DUT (.clk, .reset_n, .hv_enable_n_pin, .serial_reset_n_pin, .receive_ctl,
        .drive_data, .cfg_wr, .cfg_chan_mask, .cfg_field, .cfg_data, .channel_drive_control, .slew_code,
        .droop_long_code, .droop_short_code, .out_resistance_code, .low_leak_sel, .hv_on_receive_sel,
        .term_drive_sel);
    // inputs always move 2 ns after the edge, clear of the sampling edge
    task automatic tk(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(logic [3:0] m, cfg_field_e f, logic [3:0] d);
        cfg_chan_mask = m;
        cfg_field = f;
        cfg_data = d;
        cfg_wr = 1;
        tk();
        cfg_wr = 0;
        tk();
    endtask
    task automatic drv(logic [3:0] r, logic [3:0] d);
        want_rcv = r;
        want_data = d;
        tk(2);
    endtask
    task automatic t_rst;
        `CHK("slew", 8'h0, slew_code)
        `CHK("droop", 24'h0, {droop_long_code, droop_short_code})
        `CHK("res", {4{RES_RST}}, out_resistance_code)
        `CHK("state", {4{6'h01}}, channel_drive_control)
    endtask
    task automatic t_levels;
        wr(4'hF, F_HV_ON_RCV, 4'h1);
        for (int p = 0; p < 2; p++) begin
            drv(4'h0, p ? 4'hA : 4'h5);
            for (int c = 0; c < 4; c++) `CHK("lvl", want_data[c] ? 6'h02 : 6'h01, channel_drive_control[c])
        end
        drv(4'hF, 4'h0);
        `CHK("hvrcv", {4{6'h10}}, channel_drive_control)
    endtask
    task automatic t_term;
        wr(4'hF, F_HV_ON_RCV, 4'h0);
        wr(4'h5, F_TERM_DRIVE, 4'h1);
        for (int c = 0; c < 4; c++) `CHK("rcv", c[0] ? 6'h08 : 6'h04, channel_drive_control[c])
        drv(4'h0, 4'h0);
    endtask
    task automatic t_leak;
        wr(4'h2, F_LOW_LEAK, 4'h1);
        hv_enable_n_pin = 0;
        tk(4);
        for (int c = 0; c < 4; c++) `CHK("hvpin", c == 1 ? 6'h20 : 6'h10, channel_drive_control[c])
        hv_enable_n_pin = 1;
        wr(4'h2, F_LOW_LEAK, 4'h0);
        tk(3);
        `CHK("unleak", {4{6'h01}}, channel_drive_control)
    endtask
    task automatic t_codes;
        for (int v = 0; v < 8; v++) begin
            wr(4'h1 << v[1:0], F_SLEW, 4'(v));
            wr(4'hF, F_DROOP_LONG, 4'(v));
            wr(4'hF, F_DROOP_SHRT, 4'(7 - v));
            `CHK("slew", v[1:0], slew_code[v[1:0]])
            `CHK("dl", 3'(v), droop_long_code[3])
            `CHK("ds", 3'(7 - v), droop_short_code[0])
        end
        wr(4'h4, F_OUT_RES, 4'hF);
        wr(4'hF, cfg_field_e'(3'h7), 4'h0);
        `CHK("res", {RES_RST, 4'hF, RES_RST, RES_RST}, out_resistance_code)
    endtask
    task automatic t_sres;
        serial_reset_n_pin = 0;
        tk(4);
        wr(4'hF, F_SLEW, 4'h3);
        `CHK("sres", 8'h0, slew_code)
        `CHK("keep", 3'h7, droop_long_code[1])
        serial_reset_n_pin = 1;
        tk(4);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // run needs about 93 cycles, so 3000 only trips on a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        tk(4);
        reset_n = 1;
        t_rst();
        t_levels();
        t_term();
        t_leak();
        t_codes();
        t_sres();
        reset_n = 0;
        tk();
        reset_n = 1;
        tk();
        t_rst();
        finish_test();
    end
endmodule
`default_nettype wire

// >>> tb/tester_timing_model.sv
// tester timing logic: drives receive and data for four channels.
// assumes requests from the bench; answers one clock later.
`timescale 1ns/1ps
`default_nettype none
module tester_timing_model (
    // requests
    input  wire logic       clk,
    input  wire logic [3:0] want_rcv,
    input  wire logic [3:0] want_data,
    // to the block
    output var  logic [3:0] receive_ctl,
    output var  logic [3:0] drive_data
);
    initial begin
        receive_ctl = 4'h0;
        drive_data = 4'h0;
    end
    // no hv request here; only receive and data are passed on, 1 ns after the edge
    always @(posedge clk) begin
        receive_ctl <= #1 want_rcv;
        drive_data <= #1 want_data;
    end
endmodule
`default_nettype wire
